/* File: src/vfd_pkg.sv */
// Shared constants for the multiplexed fluorescent display driver
package vfd_pkg;
    // ---------------------------------------------------------------
    // Serial frame layout
    // ---------------------------------------------------------------
    localparam int unsigned FRAME_BITS    = 35;
    localparam int unsigned SEG_BITS      = 32;
    localparam int unsigned DUTY_BITS     = 10;
    localparam int unsigned MODE_BITS     = 3;
    // Mode bits sit at the newest end of the shift word
    localparam int unsigned MODE_POS      = 0;
    // Newest segment bit (last segment) sits right above the mode bits
    localparam int unsigned SEG_POS       = 3;
    localparam int unsigned DUTY_POS      = 3;
    // Mode codes written as {first, second, third}
    localparam logic [2:0]  MODE_SEG_ALL  = 3'h0;
    localparam logic [2:0]  MODE_SEG_ROW1 = 3'h4;
    localparam logic [2:0]  MODE_SEG_ROW2 = 3'h2;
    localparam logic [2:0]  MODE_SEG_ROW3 = 3'h6;
    localparam logic [2:0]  MODE_DUTY     = 3'h1;
    // ---------------------------------------------------------------
    // Display timing
    // ---------------------------------------------------------------
    localparam int unsigned OSC_PER_BIT   = 4;
    localparam int unsigned SLOT_BITS     = 1024;
    localparam logic [9:0]  DUTY_CLAMP    = 10'h3F8;
    localparam int unsigned ROWS          = 3;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [9:0]  DUTY_RESET    = 10'h000;
    localparam logic [31:0] SEG_RESET     = 32'h0000_0000;
    localparam logic [34:0] WORD_RESET    = 35'h0_0000_0000;
    localparam logic [2:0]  STROBE_IDLE_N = 3'h7;

    typedef logic [FRAME_BITS-1:0] vfd_word_t;
endpackage : vfd_pkg

/* File: src/vfd_link_if.sv */
// Carrier for the shifted word between the link and the display core
`timescale 1ns/1ps
`default_nettype none
interface vfd_link_if;
    import vfd_pkg::*;
    vfd_word_t word;
    modport link (output word);
    modport core (input word);
endinterface : vfd_link_if
`default_nettype wire

/* File: src/vfd_link_rx.sv */
// Serial receiver running on the host's shift clock
`timescale 1ns/1ps
`default_nettype none
module vfd_link_rx (
    input  wire logic   SHIFT_CLK,
    input  wire logic   RST_N,
    input  wire logic   CHIP_SEL,
    input  wire logic   SER_DATA,
    vfd_link_if.link    lnk
);
    import vfd_pkg::*;

    logic      rst_meta_n;
    logic      rst_link_n;
    vfd_word_t shift;

    // ---------------------------------------------------------------
    // Reset crossing into the link domain
    // ---------------------------------------------------------------
    always_ff @(posedge SHIFT_CLK) begin
        rst_meta_n <= RST_N;
        rst_link_n <= rst_meta_n;
    end

    // Shift newest bit in at the low end; the last three are the mode
    // Only the last 35 bits matter, so no bit counter is kept
    always_ff @(posedge SHIFT_CLK) begin
        if (!rst_link_n) begin
            shift <= WORD_RESET;
        end else if (CHIP_SEL) begin
            shift <= {shift[FRAME_BITS-2:0], SER_DATA};
        end
    end

    // Word is quiet while chip select is low, so the core may copy it
    assign lnk.word = shift;
endmodule : vfd_link_rx
`default_nettype wire

/* File: src/vfd_driver.sv */
// Multiplexed fluorescent display driver with serial load and dimming
// Behaviour
// - Reset clears shift word and latches
// - After reset: duty zero, anodes low, strobes high
// - Words shift only while chip select high
// - Data sampled on shift clock rising edge
// - Chip select fall loads selected latch
// - Mode decode: rows all, one, two, three, dimming
// - Mode zero writes all three row latches
// - Row modes touch only their own latch
// - Segment one lights anode in its slot
// - Segment frame: 32 segments then mode
// - Dimming frame: ten bits LSB first, mode
// - On-time equals duty, clamped at 1016
// - Bit is four clocks, slot 1024 bits
// - Master ignores duty and slot inputs
// - Master dimmer times strobes and anodes
// - Slave gates anodes by duty input
// - Slave slot inputs pick displayed latch
// - Slave: strobes high, duty/sync outputs low
// - Master select high means master mode
// - Duty select high two rows, else three
// - Row strobes are active low
// - Master drives duty output for slave
`timescale 1ns/1ps
`default_nettype none
module vfd_driver (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        SHIFT_CLK,
    input  wire logic        CHIP_SEL,
    input  wire logic        SER_DATA,
    input  wire logic        MASTER_SELECT,
    input  wire logic        DUTY_SELECT,
    input  wire logic        SLAVE_DUTY_IN,
    input  wire logic        SLOT_SEL_IN_ONE,
    input  wire logic        SLOT_SEL_IN_TWO,
    output var  logic [31:0] ANODE_OUT,
    output var  logic [2:0]  ROW_STROBE_OUT_N,
    output var  logic        MASTER_DUTY_OUT,
    output var  logic        SLOT_SYNC_OUT_ONE,
    output var  logic        SLOT_SYNC_OUT_TWO
);
    import vfd_pkg::*;

    // ---------------------------------------------------------------
    // Link domain
    // ---------------------------------------------------------------
    vfd_link_if lnk ();

    vfd_link_rx u_vfd_link_rx (
        .SHIFT_CLK (SHIFT_CLK),
        .RST_N     (RST_N),
        .CHIP_SEL  (CHIP_SEL),
        .SER_DATA  (SER_DATA),
        .lnk       (lnk.link)
    );

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    localparam int unsigned NPIN = 6;
    localparam int unsigned P_CS = 0;
    localparam int unsigned P_MS = 1;
    localparam int unsigned P_DS = 2;
    localparam int unsigned P_DI = 3;
    localparam int unsigned P_S1 = 4;
    localparam int unsigned P_S2 = 5;

    wire  [NPIN-1:0] pin_raw = {SLOT_SEL_IN_TWO, SLOT_SEL_IN_ONE, SLAVE_DUTY_IN,
                                DUTY_SELECT, MASTER_SELECT, CHIP_SEL};
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_s3;
    logic [NPIN-1:0] pin_f;

    // A level counts only once the second and third stage agree
    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++) begin : g_pin
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    pin_s1[gp] <= 1'b0;
                    pin_s2[gp] <= 1'b0;
                    pin_s3[gp] <= 1'b0;
                    pin_f[gp]  <= 1'b0;
                end else begin
                    pin_s1[gp] <= pin_raw[gp];
                    pin_s2[gp] <= pin_s1[gp];
                    pin_s3[gp] <= pin_s2[gp];
                    if (pin_s2[gp] == pin_s3[gp]) begin
                        pin_f[gp] <= pin_s3[gp];
                    end
                end
            end
        end
    endgenerate

    wire master_f = pin_f[P_MS];
    wire dup_f    = pin_f[P_DS];
    wire duty_f   = pin_f[P_DI];
    wire sel1_f   = pin_f[P_S1];
    wire sel2_f   = pin_f[P_S2];

    // Falling edge of the filtered chip select is the load strobe
    wire load = pin_f[P_CS] & (pin_s2[P_CS] == pin_s3[P_CS]) & ~pin_s3[P_CS];

    // ---------------------------------------------------------------
    // Frame decode
    // ---------------------------------------------------------------
    // Word is read only at load; shifting stopped with chip select low
    wire [2:0] mode = lnk.word[MODE_POS +: MODE_BITS];
    wire [SEG_BITS-1:0]  seg_in;
    wire [DUTY_BITS-1:0] duty_in;

    // First segment arrived earliest, so it sits highest in the word
    genvar gs;
    generate
        for (gs = 0; gs < SEG_BITS; gs++) begin : g_seg
            assign seg_in[gs] = lnk.word[SEG_POS + SEG_BITS - 1 - gs];
        end
        for (gs = 0; gs < DUTY_BITS; gs++) begin : g_duty
            assign duty_in[gs] = lnk.word[DUTY_POS + DUTY_BITS - 1 - gs];
        end
    endgenerate

    wire [ROWS-1:0] row_wr;
    assign row_wr[0] = load & ((mode == MODE_SEG_ALL) | (mode == MODE_SEG_ROW1));
    assign row_wr[1] = load & ((mode == MODE_SEG_ALL) | (mode == MODE_SEG_ROW2));
    assign row_wr[2] = load & ((mode == MODE_SEG_ALL) | (mode == MODE_SEG_ROW3));
    wire duty_wr     = load & (mode == MODE_DUTY);

    // ---------------------------------------------------------------
    // Row latches and dimming value
    // ---------------------------------------------------------------
    logic [SEG_BITS-1:0]  seg_latch [ROWS];
    logic [DUTY_BITS-1:0] duty;

    // Whole words land in one edge, so a slot never sees half a frame
    genvar gr;
    generate
        for (gr = 0; gr < ROWS; gr++) begin : g_row
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    seg_latch[gr] <= SEG_RESET;
                end else if (row_wr[gr]) begin
                    seg_latch[gr] <= seg_in;
                end
            end
        end
    endgenerate

    // Clamp on write keeps the compare below simple
    wire [DUTY_BITS-1:0] next_duty = (duty_in >= DUTY_CLAMP) ? DUTY_CLAMP : duty_in;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            duty <= DUTY_RESET;
        end else if (duty_wr) begin
            duty <= next_duty;
        end
    end

    // ---------------------------------------------------------------
    // Timing generator
    // ---------------------------------------------------------------
    localparam logic [1:0] TICK_LAST = 2'(OSC_PER_BIT - 1);

    logic [1:0] osc_cnt;
    logic [9:0] bit_cnt;
    logic [1:0] row;

    wire       tick      = (osc_cnt == TICK_LAST);
    wire       slot_end  = tick & (bit_cnt == 10'(SLOT_BITS - 1));
    wire [1:0] row_last  = dup_f ? 2'h1 : 2'h2;
    wire [1:0] next_row  = (row >= row_last) ? 2'h0 : row + 2'h1;

    // Bit time counter, then slot position, then active row
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            osc_cnt <= 2'h0;
            bit_cnt <= 10'h000;
            row     <= 2'h0;
        end else begin
            osc_cnt <= tick ? 2'h0 : osc_cnt + 2'h1;
            if (tick) begin
                bit_cnt <= bit_cnt + 10'h001;
            end
            if (slot_end) begin
                row <= next_row;
            end
        end
    end

    // ---------------------------------------------------------------
    // Output selection
    // ---------------------------------------------------------------
    // On-time spans the first duty bit times of every slot
    wire        dim_on     = (bit_cnt < duty);
    // Slot inputs {one,two}: 10 row one, 01 row two, 11 row three
    wire [1:0]  slave_row  = {sel1_f & sel2_f, sel2_f & ~sel1_f};
    wire        slave_any  = sel1_f | sel2_f;
    wire [2:0]  row_onehot = 3'h1 << row;

    wire [31:0] next_anode  = master_f ? (dim_on ? seg_latch[row] : SEG_RESET)
                            : ((slave_any & duty_f) ? seg_latch[slave_row] : SEG_RESET);
    wire [2:0]  next_strobe = (master_f & dim_on) ? ~row_onehot : STROBE_IDLE_N;
    wire        next_dout   = master_f & dim_on;
    wire        next_sync1  = master_f & (row != 2'h1);
    wire        next_sync2  = master_f & (row != 2'h0);

    // Every pin comes straight off a flop
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ANODE_OUT         <= SEG_RESET;
            ROW_STROBE_OUT_N  <= STROBE_IDLE_N;
            MASTER_DUTY_OUT   <= 1'b0;
            SLOT_SYNC_OUT_ONE <= 1'b0;
            SLOT_SYNC_OUT_TWO <= 1'b0;
        end else begin
            ANODE_OUT         <= next_anode;
            ROW_STROBE_OUT_N  <= next_strobe;
            MASTER_DUTY_OUT   <= next_dout;
            SLOT_SYNC_OUT_ONE <= next_sync1;
            SLOT_SYNC_OUT_TWO <= next_sync2;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_reset_outputs;
        @(posedge CLK_SYS) !RST_N |=> (ANODE_OUT == 32'h0000_0000) && (ROW_STROBE_OUT_N == 3'h7) && (duty == 10'h000);
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle after reset");

    property p_load_all;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (load && mode == 3'h0) |=> (seg_latch[0] == $past(seg_in)) && (seg_latch[1] == seg_latch[0])
                                    && (seg_latch[2] == seg_latch[0]);
    endproperty
    a_load_all: assert property (p_load_all) else $error("mode zero did not fill all rows");

    property p_load_one;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (load && mode == 3'h4) |=> $stable(seg_latch[1]) && $stable(seg_latch[2]) && (seg_latch[0] == $past(seg_in));
    endproperty
    a_load_one: assert property (p_load_one) else $error("row one write disturbed other rows");

    property p_load_two;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (load && mode == MODE_SEG_ROW2) |=> $stable(seg_latch[0]) && $stable(seg_latch[2])
                                            && (seg_latch[1] == $past(seg_in));
    endproperty
    a_load_two: assert property (p_load_two) else $error("row two write disturbed other rows");

    property p_load_three;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (load && mode == MODE_SEG_ROW3) |=> $stable(seg_latch[0]) && $stable(seg_latch[1])
                                            && (seg_latch[2] == $past(seg_in));
    endproperty
    a_load_three: assert property (p_load_three) else $error("row three write disturbed other rows");

    // Unused codes must leave every latch alone, duty included
    property p_load_none;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (load && mode[0] && (mode != MODE_DUTY)) |=> $stable(duty) && $stable(seg_latch[0])
                                                     && $stable(seg_latch[1]) && $stable(seg_latch[2]);
    endproperty
    a_load_none: assert property (p_load_none) else $error("unused mode code changed a latch");

    // One load per select fall, however long select stays low
    property p_load_pulse;
        @(posedge CLK_SYS) disable iff (!RST_N)
        load |=> !load;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("load strobe longer than one cycle");

    property p_duty_clamp;
        @(posedge CLK_SYS) disable iff (!RST_N)
        duty_wr |=> (duty <= 10'h3F8) && (($past(duty_in) < 10'h3F8) -> (duty == $past(duty_in)));
    endproperty
    a_duty_clamp: assert property (p_duty_clamp) else $error("duty value not clamped");

    property p_bit_time;
        @(posedge CLK_SYS) disable iff (!RST_N)
        tick |=> !tick [*3] ##1 tick;
    endproperty
    a_bit_time: assert property (p_bit_time) else $error("bit time is not four clocks");

    property p_slave_idle;
        @(posedge CLK_SYS) disable iff (!RST_N)
        !$past(master_f) |-> (ROW_STROBE_OUT_N == 3'h7) && !MASTER_DUTY_OUT && !SLOT_SYNC_OUT_ONE
                             && !SLOT_SYNC_OUT_TWO;
    endproperty
    a_slave_idle: assert property (p_slave_idle) else $error("slave outputs not idle");

    property p_slave_gate;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (!$past(master_f) && !$past(duty_f)) |-> (ANODE_OUT == 32'h0000_0000);
    endproperty
    a_slave_gate: assert property (p_slave_gate) else $error("slave anodes lit with duty low");

    property p_one_row;
        @(posedge CLK_SYS) disable iff (!RST_N)
        $onehot0(~ROW_STROBE_OUT_N) && (MASTER_DUTY_OUT == (ROW_STROBE_OUT_N != 3'h7));
    endproperty
    a_one_row: assert property (p_one_row) else $error("strobe and duty output disagree");

    property p_sync_code;
        @(posedge CLK_SYS) disable iff (!RST_N)
        $past(master_f) |-> ({SLOT_SYNC_OUT_ONE, SLOT_SYNC_OUT_TWO} ==
                            (($past(row) == 2'h0) ? 2'h2 : ($past(row) == 2'h1) ? 2'h1 : 2'h3));
    endproperty
    a_sync_code: assert property (p_sync_code) else $error("sync outputs do not match row");

    property p_duplex_rows;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (slot_end && dup_f && row == 2'h1) |=> (row == 2'h0);
    endproperty
    a_duplex_rows: assert property (p_duplex_rows) else $error("two-row scan did not wrap");

    property p_triplex_rows;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (slot_end && !dup_f && row == 2'h2) |=> (row == 2'h0);
    endproperty
    a_triplex_rows: assert property (p_triplex_rows) else $error("three-row scan did not wrap");

    // Outside the on-time a master shows nothing at all
    property p_master_dark;
        @(posedge CLK_SYS) disable iff (!RST_N)
        ($past(master_f) && !$past(dim_on)) |-> (ANODE_OUT == 32'h0000_0000) && (ROW_STROBE_OUT_N == 3'h7);
    endproperty
    a_master_dark: assert property (p_master_dark) else $error("master lit outside its on-time");

    // Both slot inputs low means no latch is shown
    property p_slave_none;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (!$past(master_f) && !$past(sel1_f) && !$past(sel2_f)) |-> (ANODE_OUT == 32'h0000_0000);
    endproperty
    a_slave_none: assert property (p_slave_none) else $error("slave lit with no slot selected");
endmodule : vfd_driver
`default_nettype wire

/* File: tb/vfd_host_model.sv */
// Host side of the serial link: frames words onto the three-wire port
`timescale 1ns/1ps
`default_nettype none
module vfd_host_model (
    output var logic SHIFT_CLK,
    output var logic CHIP_SEL,
    output var logic SER_DATA
);
    // ---------------------------------------------------------------
    // Link idle state
    // ---------------------------------------------------------------
    // Clock stands still and select stays low between frames
    initial begin
        SHIFT_CLK = 1'b0;
        CHIP_SEL  = 1'b0;
        SER_DATA  = 1'b0;
    end

    // Clock pulses with select low, so the reset reaches the shift side
    task automatic idle(input int n);
        repeat (n) begin
            #7.5 SHIFT_CLK = 1'b1;
            #7.5 SHIFT_CLK = 1'b0;
        end
    endtask : idle

    // ---------------------------------------------------------------
    // One frame, bit 0 first; slow stretches each half period
    // ---------------------------------------------------------------
    task automatic send(input logic [47:0] w, input int n, input bit slow);
        CHIP_SEL = 1'b1;
        #20;
        for (int i = 0; i < n; i++) begin
            SER_DATA = w[i];
            #(slow ? 500 : 7.5) SHIFT_CLK = 1'b1;
            #(slow ? 500 : 7.5) SHIFT_CLK = 1'b0;
        end
        #20 CHIP_SEL = 1'b0;
        // Released line shows the inverse, so a held value never passes
        SER_DATA = ~SER_DATA;
    endtask : send
endmodule : vfd_host_model
`default_nettype wire

/* File: tb/vfd_driver_bench.sv */
// Self-checking bench for the display driver
`timescale 1ns/1ps
`default_nettype none
module vfd_driver_bench;
    import vfd_pkg::*;
    typedef struct packed {
        logic [31:0] anode;
        logic [2:0]  strobe;
        logic        dout;
        logic [1:0]  sync;
    } vfd_obs_t;
    logic        clk_sys, rst_n, shift_clk, chip_sel, ser_data, look;
    logic        master_select, duty_select, slave_duty_in, sel_one, sel_two;
    logic [31:0] anode_out;
    logic [2:0]  row_strobe_out_n;
    logic        master_duty_out, sync_one, sync_two;
    logic [31:0] lat [3];
    vfd_obs_t    q [$];
    int          n_mismatch, check_count, cyc;

    // ---------------------------------------------------------------
    // Clock, partner and design
    // ---------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    vfd_host_model u_vfd_host_model (.SHIFT_CLK(shift_clk), .CHIP_SEL(chip_sel), .SER_DATA(ser_data));
    vfd_driver u_vfd_driver (.CLK_SYS(clk_sys), .RST_N(rst_n), .SHIFT_CLK(shift_clk), .CHIP_SEL(chip_sel),
        .SER_DATA(ser_data), .MASTER_SELECT(master_select), .DUTY_SELECT(duty_select),
        .SLAVE_DUTY_IN(slave_duty_in), .SLOT_SEL_IN_ONE(sel_one), .SLOT_SEL_IN_TWO(sel_two),
        .ANODE_OUT(anode_out), .ROW_STROBE_OUT_N(row_strobe_out_n), .MASTER_DUTY_OUT(master_duty_out),
        .SLOT_SYNC_OUT_ONE(sync_one), .SLOT_SYNC_OUT_TWO(sync_two));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [37:0] seen, input logic [37:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // Inputs set after tick move one nanosecond after the edge; the host model pins keep their own timing
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    function automatic logic [1:0] rsel(input int r);
        return r == 0 ? 2'h2 : (r == 1 ? 2'h1 : 2'h3);
    endfunction : rsel

    // Note the expectation, then flag that the outputs are ready
    task automatic note(input vfd_obs_t e);
        q.push_back(e);
        look = 1'b1;
        tick(1);
        look = 1'b0;
    endtask : note

    // Oldest note against the outputs of this moment
    always @(posedge look) begin
        if (q.size() == 0) begin
            n_mismatch++;
            $display("ERROR %0t: result with no expectation", $time);
        end else check({anode_out, row_strobe_out_n, master_duty_out, sync_one, sync_two}, q.pop_front());
    end

    task automatic frame(input logic [2:0] m, input logic [31:0] v, input bit slow);
        u_vfd_host_model.send({13'h0000, m[0], m[1], m[2], v}, 35, slow);
        tick(20);
    endtask : frame

    task automatic slave_look(input int r, input logic gate, input logic [31:0] e);
        {sel_one, sel_two} = r < 0 ? 2'h0 : rsel(r);
        slave_duty_in = gate;
        tick(10);
        note({e, 3'h7, 1'b0, 2'h0});
    endtask : slave_look

    // Bounded wait for a level on the duty output
    task automatic wait_duty(input logic v);
        int t;
        t = 0;
        while (master_duty_out !== v) begin
            tick(1);
            t++;
            if (t > 9000) begin
                n_mismatch++;
                $display("ERROR %0t: duty output never reached %b", $time, v);
                stop_test();
            end
        end
    endtask : wait_duty

    // One master slot: shown row, strobe, sync code and on-time
    task automatic slot(inout int row, input int on, output int rise);
        int t;
        {sel_one, sel_two, slave_duty_in} = 3'($urandom());
        wait_duty(1'b0);
        wait_duty(1'b1);
        rise = cyc;
        tick(2);
        if (row < 0) row = row_strobe_out_n === 3'h6 ? 0 : (row_strobe_out_n === 3'h5 ? 1 : 2);
        note({lat[row], ~(3'h1 << row), 1'b1, rsel(row)});
        t = 3;
        while (master_duty_out === 1'b1 && t < 9000) begin
            tick(1);
            t++;
        end
        check(38'(t), 38'(on));
    endtask : slot

    task automatic master_run(input int d, input int rows);
        int row, r0, r1;
        row = -1;
        u_vfd_host_model.send({35'h0, MODE_DUTY[0], MODE_DUTY[1], MODE_DUTY[2], 10'(d)}, 13, 1'b0);
        tick(20);
        for (int k = 0; k < rows + 1; k++) begin
            slot(row, (d >= 1016 ? 1016 : d) * OSC_PER_BIT, r1);
            if (k > 0) check(38'(r1 - r0), 38'(SLOT_BITS * OSC_PER_BIT));
            r0 = r1;
            row = (row + 1) % rows;
        end
    endtask : master_run

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        int bad;
        logic [31:0] v;
        logic [2:0] code [3];
        code = '{MODE_SEG_ROW1, MODE_SEG_ROW2, MODE_SEG_ROW3};
        {rst_n, duty_select, slave_duty_in, sel_one, sel_two, look} = 6'h00;
        master_select = 1'b1;
        n_mismatch = 0;
        check_count = 0;
        bad = 0;
        void'($urandom(26717));
        fork
            tick(5);
            u_vfd_host_model.idle(3);
        join
        note({32'h0, 3'h7, 1'b0, 2'h0});
        rst_n = 1'b1;
        // Shift side leaves reset only after its own clock has ticked
        u_vfd_host_model.idle(3);
        // Master with zero duty must stay dark over a whole slot
        repeat (4500) begin
            tick(1);
            if (master_duty_out !== 1'b0 || anode_out !== 32'h0 || row_strobe_out_n !== 3'h7) bad++;
        end
        check(38'(bad), 38'h0);
        master_select = 1'b0;
        slave_look(0, 1'b1, 32'h0);
        v = $urandom();
        frame(MODE_SEG_ALL, v, 1'b0);
        for (int r = 0; r < 3; r++) lat[r] = v;
        for (int r = 0; r < 3; r++) begin
            v = $urandom();
            frame(code[r], v, r == 0);
            lat[r] = v;
            for (int s = 0; s < 3; s++) slave_look(s, 1'b1, lat[s]);
        end
        frame(3'h5, $urandom(), 1'b0);
        slave_look(2, 1'b1, lat[2]);
        // Stray leading bits drop out; only the last 35 count
        v = $urandom();
        u_vfd_host_model.send({8'h00, MODE_SEG_ROW2[0], MODE_SEG_ROW2[1], MODE_SEG_ROW2[2], v, 5'h15}, 40, 1'b0);
        tick(20);
        lat[1] = v;
        slave_look(1, 1'b1, v);
        slave_look(-1, 1'b1, 32'h0);
        slave_look(1, 1'b0, 32'h0);
        master_select = 1'b1;
        duty_select = 1'b1;
        master_run(20, 2);
        duty_select = 1'b0;
        master_run(1016 + $urandom_range(7), 3);
        stop_test();
    end
endmodule : vfd_driver_bench
`default_nettype wire
